// ===== hdl/cspr_regs.v
// Function
// - raw alignment bit picks lsb or msb
// - register-control bit on top, reset zero
// - port 0 enable field resets to 3f
// - port 1 enable field resets to 00
// - route bit 2 drives pass on pin 3
// - route bit 1 drives pin 0, default
// - bit 0 reads pass; upper bits 02
// - vc field stamps packet header channel
// - host uses address then data port
`timescale 1ns/1ps
`default_nettype none
`include "cspr_defs.vh"

module cspr_regs (
  input  wire        clk_in,            // device clock, 100 MHz
  input  wire        rst_n_in,          // async digital reset
  input  wire        bus_wr_in,         // serial bus write strobe
  input  wire        bus_rd_in,         // serial bus read strobe
  input  wire [7:0]  bus_addr_in,       // serial bus register address
  input  wire [7:0]  bus_wdata_in,      // serial bus write data
  input  wire        pass_in,           // pass indication from video path
  output reg  [7:0]  bus_rdata_out,     // read data, registered
  output reg         raw_msb_out,       // raw samples on msbs
  output reg         port0_reg_ctl_out, // port 0 under register control
  output reg  [5:0]  port0_enable_out,  // port 0 lane enables
  output reg         port1_reg_ctl_out, // port 1 under register control
  output reg  [5:0]  port1_enable_out,  // port 1 lane enables
  output reg         general_pin_3_out, // pass seen on pin 3
  output reg         general_pin_3_oe_out, // pin 3 driven
  output reg         general_pin_0_out, // pass seen on pin 0
  output reg         general_pin_0_oe_out, // pin 0 driven
  output reg  [1:0]  vc_id_out          // header virtual channel
);

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  reg [7:0] indirect_address_port_r; // offset pointer
  reg       raw_align_r;             // raw placement
  reg       en0_ctl_r;               // port 0 control
  reg [5:0] en0_field_r;             // port 0 field
  reg       en1_ctl_r;               // port 1 control
  reg [5:0] en1_field_r;             // port 1 field
  reg [1:0] route_r;                 // {pin3, pin0} routing
  reg [1:0] vc_r;                    // virtual channel
  reg [7:0] rd_nxt;                  // mux of read data

  // --------------------------------------------------------------
  // reset constants
  // --------------------------------------------------------------
  // whole alignment register default, only one bit of it is stored
  localparam [7:0] RAW_RST   = `CSPR_RST_RAW;
  // routing default, pin 0 carries pass after reset
  localparam [1:0] ROUTE_RST = `CSPR_RST_ROUTE;

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  // write into address port moves the offset pointer
  wire addr_wr = bus_wr_in && (bus_addr_in == `CSPR_IA_ADDR);
  // write into data port hits the pointed register
  wire data_wr = bus_wr_in && (bus_addr_in == `CSPR_ID_ADDR);

  // --------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------
  // reserved bits are never stored, so rmw cannot disturb them
  // writes skip reserved bits
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // offset pointer clears
      indirect_address_port_r <= `CSPR_RST_PTR;
      raw_align_r             <= RAW_RST[`CSPR_RAW_BIT];
      en0_ctl_r               <= `CSPR_RST_CTL;
      en0_field_r             <= `CSPR_RST_EN0;
      en1_ctl_r               <= `CSPR_RST_CTL;
      en1_field_r             <= `CSPR_RST_EN1;
      route_r                 <= `CSPR_RST_ROUTE;
      vc_r                    <= `CSPR_RST_VC;
    end else begin
      if (addr_wr) begin
        indirect_address_port_r <= bus_wdata_in;
      end
      if (data_wr) begin
        case (indirect_address_port_r)
          `CSPR_OFS_RAW: begin
            raw_align_r <= bus_wdata_in[`CSPR_RAW_BIT];
          end
          `CSPR_OFS_EN0: begin
            en0_ctl_r   <= bus_wdata_in[`CSPR_REGCTL_BIT];
            en0_field_r <= bus_wdata_in[`CSPR_EN_HI:0];
          end
          `CSPR_OFS_EN1: begin
            en1_ctl_r   <= bus_wdata_in[`CSPR_REGCTL_BIT];
            en1_field_r <= bus_wdata_in[`CSPR_EN_HI:0];
          end
          `CSPR_OFS_PASS: begin
            route_r <= bus_wdata_in[`CSPR_PASS_G3_BIT:`CSPR_PASS_G0_BIT];
          end
          `CSPR_OFS_VC: begin
            vc_r <= bus_wdata_in[`CSPR_VC_HI:`CSPR_VC_LO];
          end
          default: begin
            // unmapped offsets ignore writes
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------
  // combinational select; the read strobe gates it at the output flop
  always @* begin
    // default covers every address outside the port pair
    rd_nxt = 8'h00;
    if (bus_addr_in == `CSPR_IA_ADDR) begin
      rd_nxt = indirect_address_port_r;
    end else if (bus_addr_in == `CSPR_ID_ADDR) begin
      case (indirect_address_port_r)
        `CSPR_OFS_RAW: begin
          rd_nxt = {3'h0, raw_align_r, 4'h0};
        end
        `CSPR_OFS_EN0: begin
          rd_nxt = {en0_ctl_r, 1'b0, en0_field_r};
        end
        `CSPR_OFS_EN1: begin
          rd_nxt = {en1_ctl_r, 1'b0, en1_field_r};
        end
        `CSPR_OFS_PASS: begin
          rd_nxt = {`CSPR_RST_PASS_HI, route_r, pass_in};
        end
        `CSPR_OFS_VC: begin
          rd_nxt = {vc_r, 6'h00};
        end
        // unmapped offsets read zero
        default: begin
          rd_nxt = 8'h00;
        end
      endcase
    end else begin
      // other serial bus addresses belong elsewhere
      rd_nxt = 8'h00;
    end
  end

  // --------------------------------------------------------------
  // output flops
  // --------------------------------------------------------------
  // read data stands one cycle after the strobe and idles at zero,
  // so a host that samples late sees zero rather than a stale value
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_rdata_out <= 8'h00;
    end else if (bus_rd_in) begin
      bus_rdata_out <= rd_nxt;
    end else begin
      // idle between reads
      bus_rdata_out <= 8'h00;
    end
  end

  // --------------------------------------------------------------
  // control output flops
  // --------------------------------------------------------------
  // one cycle behind the stored fields; the video path sees a write
  // two edges after the data-port strobe
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      raw_msb_out       <= RAW_RST[`CSPR_RAW_BIT];
      port0_reg_ctl_out <= `CSPR_RST_CTL;
      port0_enable_out  <= `CSPR_RST_EN0;
      port1_reg_ctl_out <= `CSPR_RST_CTL;
      port1_enable_out  <= `CSPR_RST_EN1;
      vc_id_out         <= `CSPR_RST_VC;
    end else begin
      raw_msb_out       <= raw_align_r;
      port0_reg_ctl_out <= en0_ctl_r;
      port0_enable_out  <= en0_field_r;
      port1_reg_ctl_out <= en1_ctl_r;
      port1_enable_out  <= en1_field_r;
      vc_id_out         <= vc_r;
    end
  end

  // --------------------------------------------------------------
  // pass pin flops
  // --------------------------------------------------------------
  // pass reaches a pin one cycle late; both routes may be on at once,
  // and each pin is driven only while its route bit is set
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      general_pin_3_out    <= 1'b0;
      general_pin_3_oe_out <= ROUTE_RST[1];
      general_pin_0_out    <= 1'b0;
      general_pin_0_oe_out <= ROUTE_RST[0];
    end else begin
      general_pin_3_out    <= route_r[1] & pass_in;
      general_pin_3_oe_out <= route_r[1];
      general_pin_0_out    <= route_r[0] & pass_in;
      general_pin_0_oe_out <= route_r[0];
    end
  end

endmodule // cspr_regs
`default_nettype wire

// ===== hdl/cspr_defs.vh
`ifndef CSPR_DEFS_VH
`define CSPR_DEFS_VH
// indirect port addresses on the serial control bus
`define CSPR_IA_ADDR        8'h6c
`define CSPR_ID_ADDR        8'h6d
// indirect register offsets
`define CSPR_OFS_RAW        8'h09
`define CSPR_OFS_EN0        8'h13
`define CSPR_OFS_EN1        8'h14
`define CSPR_OFS_PASS       8'h16
`define CSPR_OFS_VC         8'h2e
// field positions
`define CSPR_RAW_BIT        4
`define CSPR_REGCTL_BIT     7
`define CSPR_EN_HI          5
`define CSPR_PASS_G3_BIT    2
`define CSPR_PASS_G0_BIT    1
`define CSPR_VC_HI          7
`define CSPR_VC_LO          6
// reset values
`define CSPR_RST_RAW        8'h00
`define CSPR_RST_EN0        6'h3f
`define CSPR_RST_EN1        6'h00
`define CSPR_RST_PASS_HI    5'h02
`define CSPR_RST_ROUTE      2'h1
`define CSPR_RST_VC         2'h0
// offset pointer after reset
`define CSPR_RST_PTR        8'h00
// register-control bits after reset
`define CSPR_RST_CTL        1'b0
`define CSPR_EN_ALL         6'h3f
`endif

// ===== dv/cspr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cspr_regs_sva (
  input wire logic       clk_in, rst_n_in, bus_wr_in, bus_rd_in, pass_in,
  input wire logic [7:0] bus_addr_in, bus_wdata_in, bus_rdata_out,
  input wire logic       port0_reg_ctl_out, port1_reg_ctl_out,
  input wire logic [5:0] port0_enable_out, port1_enable_out,
  input wire logic       general_pin_3_out, general_pin_3_oe_out, general_pin_0_out, general_pin_0_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] ptr_r;                                    // shadow of the offset pointer
  wire        dwr = bus_wr_in && bus_addr_in == 8'h6d; // data port write
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in) ptr_r <= 8'h00;
    else if (bus_wr_in && bus_addr_in == 8'h6c) ptr_r <= bus_wdata_in;
  rd_idle_a: assert property (!$past(bus_rd_in) |-> bus_rdata_out == 8'h00)
    else $error("rdata not idle");
  ptr_read_a: assert property (bus_rd_in && bus_addr_in == 8'h6c |=> bus_rdata_out == $past(ptr_r))
    else $error("pointer readback");
  pass_top_a: assert property (bus_rd_in && bus_addr_in == 8'h6d && ptr_r == 8'h16 |=>
    bus_rdata_out[7:3] == 5'h02) else $error("pass top bits");
  en0_write_a: assert property (dwr && ptr_r == 8'h13 |-> ##2
    {port0_reg_ctl_out, 1'b0, port0_enable_out} == ($past(bus_wdata_in, 2) & 8'hbf)) else $error("port 0 enable");
  en1_write_a: assert property (dwr && ptr_r == 8'h14 |-> ##2
    {port1_reg_ctl_out, 1'b0, port1_enable_out} == ($past(bus_wdata_in, 2) & 8'hbf)) else $error("port 1 enable");
  route_write_a: assert property (dwr && ptr_r == 8'h16 |-> ##2
    {5'h00, general_pin_3_oe_out, general_pin_0_oe_out, 1'b0} == ($past(bus_wdata_in, 2) & 8'h06))
    else $error("pin routing");
  // pin level lags pass by one edge; an edge in reset holds the pin low
  pin0_pass_a: assert property ($past(rst_n_in) |->
    general_pin_0_out == ($past(pass_in) && general_pin_0_oe_out)) else $error("pin 0 level");
  pin3_pass_a: assert property ($past(rst_n_in) |->
    general_pin_3_out == ($past(pass_in) && general_pin_3_oe_out)) else $error("pin 3 level");
endmodule // cspr_regs_sva
bind cspr_regs cspr_regs_sva u_sva (.*);
`default_nettype wire

// ===== dv/cspr_host.sv
`timescale 1ns/1ps
`default_nettype none
module cspr_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] bus_rdata_in,
  output var  logic       bus_wr_out = 1'b0,
  output var  logic       bus_rd_out = 1'b0,
  output var  logic [7:0] bus_addr_out = 8'h00,
  output var  logic [7:0] bus_wdata_out = 8'h00
);
  // one write strobe; lines flip after release so stale values never match
  task automatic put(input logic [7:0] a, d);
    @(posedge clk_in);
    {bus_wr_out, bus_addr_out, bus_wdata_out} <= {1'b1, a, d};
    @(posedge clk_in);
    {bus_wr_out, bus_addr_out, bus_wdata_out} <= {1'b0, ~a, ~d};
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    {bus_rd_out, bus_addr_out} <= {1'b1, a};
    @(posedge clk_in);
    {bus_rd_out, bus_addr_out} <= {1'b0, ~a};
    @(negedge clk_in);
    d = bus_rdata_in;
  endtask
  task automatic wr(input logic [7:0] ofs, v);
    put(8'h6c, ofs);
    put(8'h6d, v);
  endtask
  task automatic rdr(input logic [7:0] ofs, output logic [7:0] v);
    put(8'h6c, ofs);
    get(8'h6d, v);
  endtask
endmodule // cspr_host
`default_nettype wire

// ===== dv/cspr_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cspr_regs_bench;
  logic clk_in = 1'b0, rst_n_in = 1'b0, pass_in = 1'b0, bus_wr_in, bus_rd_in, raw_msb_out, port0_reg_ctl_out;
  logic port1_reg_ctl_out, general_pin_3_out, general_pin_3_oe_out, general_pin_0_out, general_pin_0_oe_out;
  logic [7:0] bus_addr_in, bus_wdata_in, bus_rdata_out, rd;
  logic [5:0] port0_enable_out, port1_enable_out;
  logic [1:0] vc_id_out;
  int         miscompares = 0, num_checks = 0, cycles = 0;
  wire  [7:0] en0 = {port0_reg_ctl_out, 1'b0, port0_enable_out};
  wire  [7:0] en1 = {port1_reg_ctl_out, 1'b0, port1_enable_out};
  wire  [7:0] pins = {4'h0, general_pin_3_oe_out, general_pin_3_out, general_pin_0_oe_out, general_pin_0_out};
  cspr_regs dut (
    .clk_in               (clk_in),
    .rst_n_in             (rst_n_in),
    .bus_wr_in            (bus_wr_in),
    .bus_rd_in            (bus_rd_in),
    .bus_addr_in          (bus_addr_in),
    .bus_wdata_in         (bus_wdata_in),
    .pass_in              (pass_in),
    .bus_rdata_out        (bus_rdata_out),
    .raw_msb_out          (raw_msb_out),
    .port0_reg_ctl_out    (port0_reg_ctl_out),
    .port0_enable_out     (port0_enable_out),
    .port1_reg_ctl_out    (port1_reg_ctl_out),
    .port1_enable_out     (port1_enable_out),
    .general_pin_3_out    (general_pin_3_out),
    .general_pin_3_oe_out (general_pin_3_oe_out),
    .general_pin_0_out    (general_pin_0_out),
    .general_pin_0_oe_out (general_pin_0_oe_out),
    .vc_id_out            (vc_id_out)
  );
  cspr_host host (.clk_in(clk_in), .bus_rdata_in(bus_rdata_out), .bus_wr_out(bus_wr_in), .bus_rd_out(bus_rd_in),
                  .bus_addr_out(bus_addr_in), .bus_wdata_out(bus_wdata_in));
  initial forever #5 clk_in = ~clk_in;
  task automatic chk(input string n, input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic conclude;
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard: whole run needs about 115 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic settle;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic t_reset;
    chk("en0", en0, 8'h3f);
    chk("en1", en1, 8'h00);
    chk("pins", pins, 8'h02);
    chk("raw", {7'h00, raw_msb_out}, 8'h00);
    chk("vc", {6'h00, vc_id_out}, 8'h00);
    host.rdr(8'h16, rd);
    chk("pass rd", rd, 8'h12);
  endtask
  task automatic t_ports;
    host.wr(8'h13, 8'hc0);
    host.wr(8'h14, 8'hff);
    settle();
    chk("en0 w", en0, 8'h80);
    chk("en1 w", en1, 8'hbf);
    host.rdr(8'h13, rd);
    chk("en0 rd", rd, 8'h80);
    host.get(8'h6c, rd);
    chk("ptr", rd, 8'h13);
  endtask
  task automatic t_vc;
    for (int v = 0; v < 4; v++) begin
      host.wr(8'h2e, {v[1:0], 6'h3f});
      host.wr(8'h09, {3'h7, v[0], 4'hf});
      settle();
      chk("vc", {6'h00, vc_id_out}, v[7:0]);
      chk("raw", {7'h00, raw_msb_out}, {7'h00, v[0]});
      host.rdr(8'h2e, rd);
      chk("vc rd", rd, {v[1:0], 6'h00});
    end
  endtask
  task automatic t_pass;
    host.wr(8'h16, 8'hfe);
    pass_in <= 1'b1;
    settle();
    chk("route", pins, 8'h0f);
    host.rdr(8'h16, rd);
    chk("pass rd", rd, 8'h17);
    host.wr(8'h16, 8'h00);
    settle();
    chk("off", pins, 8'h00);
    host.rdr(8'h50, rd);
    chk("unmapped", rd, 8'h00);
  endtask
  // mid-run reset with pass still high: defaults come back, pin 0 follows pass again
  task automatic t_rerst;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk("en0 rst", en0, 8'h3f);
    chk("en1 rst", en1, 8'h00);
    chk("pins rst", pins, 8'h02);
    host.rdr(8'h16, rd);
    chk("pass live", rd, 8'h13);
    chk("pin0 pass", pins, 8'h03);
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    t_reset();
    t_ports();
    t_vc();
    t_pass();
    t_rerst();
    conclude();
  end
endmodule // cspr_regs_bench
`default_nettype wire
